// [rtl/sblu_core.sv]
// Purpose: Branch and loop sequencing for one node
// Assumes: Sequencer supplies the current slot opcode and its target
// Notes: Stack storage lives outside; this block issues stack ops
`timescale 1ns/1ps
`default_nettype none
module sblu_core #(
	parameter int ADDR_W = sblu_pkg::ADDR_W
)
(
	input wire logic CLK,
	input wire logic RESET_N,
	input wire logic WORD_VALID,
	input var sblu_pkg::sblu_slot_t SLOT_IN,
	input var sblu_pkg::sblu_stack_t STACK_IN,
	output logic FETCH_REQ,
	output logic [ADDR_W-1:0] PC,
	output logic [1:0] SLOT,
	output var sblu_pkg::sblu_stack_op_t STACK_OP
);
	typedef enum {SBLU_FETCH, SBLU_EXEC} sblu_state_t;

	// ******************************************************************
	// Decode helpers
	// ******************************************************************
	// Whole data word is zero
	function automatic logic is_zero(input logic [sblu_pkg::DATA_W-1:0] v);
		is_zero = (v == '0);
	endfunction

	// Sign bit of a data word
	function automatic logic is_negative(input logic [sblu_pkg::DATA_W-1:0] v);
		is_negative = v[sblu_pkg::SIGN_BIT];
	endfunction

	// Opcode that tests the return-stack counter
	function automatic logic is_loop_test(input logic [sblu_pkg::OP_W-1:0] o);
		is_loop_test = (o == sblu_pkg::OP_NEXT) || (o == sblu_pkg::OP_UNEXT);
	endfunction

	// ******************************************************************
	// Internal signals
	// ******************************************************************
	sblu_state_t state_r;
	sblu_state_t state_nxt;
	logic [ADDR_W-1:0] pc_r;
	logic [ADDR_W-1:0] pc_nxt;
	logic [1:0] slot_r;
	logic [1:0] slot_nxt;
	sblu_pkg::sblu_stack_op_t op_r;
	sblu_pkg::sblu_stack_op_t op_nxt;
	logic executing;
	logic fetch_take;
	logic [sblu_pkg::OP_W-1:0] cur_op;
	logic [ADDR_W-1:0] tgt;
	logic t_zero;
	logic t_neg;
	logic r_zero;
	logic loop_run;
	logic loop_end;
	logic micro_repeat;
	logic last_slot;
	logic taken;

	// ******************************************************************
	// Word fetch
	// ******************************************************************
	// A word is taken only while no slot is executing
	assign executing = (state_r == SBLU_EXEC);
	assign fetch_take = (state_r == SBLU_FETCH) && WORD_VALID;

	// ******************************************************************
	// Slot decode
	// ******************************************************************
	assign cur_op = SLOT_IN.op;
	assign tgt = ADDR_W'(SLOT_IN.target);
	assign t_zero = is_zero(STACK_IN.t);
	assign t_neg = is_negative(STACK_IN.t);
	assign r_zero = is_zero(STACK_IN.r);
	assign loop_run = is_loop_test(cur_op) && !r_zero;
	assign loop_end = is_loop_test(cur_op) && r_zero;
	assign micro_repeat = executing && (cur_op == sblu_pkg::OP_UNEXT) && !r_zero;
	assign last_slot = (slot_r == sblu_pkg::SLOT_LAST);

	// ******************************************************************
	// Branch resolution
	// ******************************************************************
	// Taken branches load the counter; all else falls through
	always_comb
	begin
		taken = 1'b0;
		if (executing)
		begin
			case (cur_op)
				sblu_pkg::OP_JUMP: taken = 1'b1;
				sblu_pkg::OP_IFZ: taken = t_zero;
				sblu_pkg::OP_IFNEG: taken = !t_neg;
				sblu_pkg::OP_NEXT: taken = !r_zero;
				default: taken = 1'b0;
			endcase
		end
	end

	// ******************************************************************
	// Stack operations
	// ******************************************************************
	// The IFZ and IFNEG branches issue no stack operation at all
	always_comb
	begin
		op_nxt = '0;
		if (executing)
		begin
			case (cur_op)
				sblu_pkg::OP_FOR:
				begin
					op_nxt.push_r = 1'b1;
					op_nxt.pop_d = 1'b1;
				end
				sblu_pkg::OP_NEXT, sblu_pkg::OP_UNEXT:
				begin
					op_nxt.dec_r = loop_run;
					op_nxt.pop_r = loop_end;
				end
				default: op_nxt = '0;
			endcase
		end
	end

	// ******************************************************************
	// Next state
	// ******************************************************************
	always_comb
	begin
		state_nxt = state_r;
		case (state_r)
			SBLU_FETCH:
			begin
				if (fetch_take)
					state_nxt = SBLU_EXEC;
			end
			SBLU_EXEC:
			begin
				if (taken)
					state_nxt = SBLU_FETCH;
				else if (micro_repeat)
					state_nxt = SBLU_EXEC;
				else if (last_slot)
					state_nxt = SBLU_FETCH;
			end
			default: state_nxt = SBLU_FETCH;
		endcase
	end

	// ******************************************************************
	// Next program counter and slot
	// ******************************************************************
	// Counter moves on a fetch or a taken branch, never otherwise
	always_comb
	begin
		pc_nxt = pc_r;
		if (fetch_take)
			pc_nxt = pc_r + ADDR_W'(1);
		else if (taken)
			pc_nxt = tgt;
	end

	// A micro loop rewinds to slot zero inside the same word
	always_comb
	begin
		slot_nxt = slot_r;
		if (fetch_take)
			slot_nxt = sblu_pkg::SLOT_FIRST;
		else if (executing && !taken)
		begin
			if (micro_repeat)
				slot_nxt = sblu_pkg::SLOT_FIRST;
			else if (!last_slot)
				slot_nxt = slot_r + 2'h1;
		end
	end

	// ******************************************************************
	// Registers
	// ******************************************************************
	// Sequencer state
	always_ff @(posedge CLK or negedge RESET_N)
	begin
		if (!RESET_N)
			state_r <= SBLU_FETCH;
		else
			state_r <= state_nxt;
	end

	// Program counter
	always_ff @(posedge CLK or negedge RESET_N)
	begin
		if (!RESET_N)
			pc_r <= sblu_pkg::PC_RESET;
		else
			pc_r <= pc_nxt;
	end

	// Slot pointer
	always_ff @(posedge CLK or negedge RESET_N)
	begin
		if (!RESET_N)
			slot_r <= sblu_pkg::SLOT_FIRST;
		else
			slot_r <= slot_nxt;
	end

	// Stack operation pulses, one cycle wide
	always_ff @(posedge CLK or negedge RESET_N)
	begin
		if (!RESET_N)
			op_r <= '0;
		else
			op_r <= op_nxt;
	end

	// ******************************************************************
	// Outputs
	// ******************************************************************
	assign FETCH_REQ = (state_r == SBLU_FETCH);
	assign PC = pc_r;
	assign SLOT = slot_r;
	assign STACK_OP = op_r;
endmodule
`default_nettype wire

// [common/sblu_pkg.sv]
// Purpose: Constants and carriers for the stack core branch and loop unit
// Assumes: 18-bit data words, four slots of five-bit opcodes per word
// Notes: Opcode values are local encodings for this unit only
package sblu_pkg;
	// ******************************************************************
	// Widths and encodings
	// ******************************************************************
	localparam int DATA_W = 18;
	localparam int ADDR_W = 10;
	localparam int SLOTS = 4;
	localparam int OP_W = 5;
	localparam int SIGN_BIT = DATA_W - 1;
	localparam logic [ADDR_W-1:0] PC_RESET = 10'h000;
	localparam logic [1:0] SLOT_FIRST = 2'h0;
	localparam logic [1:0] SLOT_LAST = 2'h3;
	localparam logic [OP_W-1:0] OP_JUMP = 5'h02;
	localparam logic [OP_W-1:0] OP_NEXT = 5'h01;
	localparam logic [OP_W-1:0] OP_UNEXT = 5'h00;
	localparam logic [OP_W-1:0] OP_IFZ = 5'h06;
	localparam logic [OP_W-1:0] OP_IFNEG = 5'h07;
	localparam logic [OP_W-1:0] OP_FOR = 5'h1D;

	typedef struct packed {
		logic [OP_W-1:0] op;
		logic [ADDR_W-1:0] target;
	} sblu_slot_t;

	typedef struct packed {
		logic [DATA_W-1:0] t;
		logic [DATA_W-1:0] r;
	} sblu_stack_t;

	typedef struct packed {
		logic pop_r;
		logic push_r;
		logic dec_r;
		logic pop_d;
	} sblu_stack_op_t;
endpackage

// [verif/sblu_chk.sv]
// Purpose: Port checks for the branch and loop unit
// Assumes: Stack ops show one cycle after execution
// Notes: Bound to sblu_core
`timescale 1ns/1ps
`default_nettype none
module sblu_chk #(
	parameter int ADDR_W = sblu_pkg::ADDR_W
)
(
	input wire logic CLK,
	input wire logic RESET_N,
	input wire logic WORD_VALID,
	input var sblu_pkg::sblu_slot_t SLOT_IN,
	input var sblu_pkg::sblu_stack_t STACK_IN,
	input wire logic FETCH_REQ,
	input wire logic [ADDR_W-1:0] PC,
	input wire logic [1:0] SLOT,
	input var sblu_pkg::sblu_stack_op_t STACK_OP
);
	// ****
	// Properties
	// ****
	default clocking @(posedge CLK);
	endclocking
	default disable iff (!RESET_N);
	wire logic [4:0] op = SLOT_IN.op;
	wire logic x = !FETCH_REQ;
	wire logic z = STACK_IN.r == 18'h0;
	wire logic c = x && (op == sblu_pkg::OP_IFZ || op == sblu_pkg::OP_IFNEG);
	wire logic tk = op == sblu_pkg::OP_IFZ ? STACK_IN.t == 18'h0 : !STACK_IN.t[17];
	wire logic lp = x && (op == sblu_pkg::OP_NEXT || op == sblu_pkg::OP_UNEXT);
	fetch_take_a: assert property (FETCH_REQ && WORD_VALID |=>
		x && SLOT == 2'h0 && PC == $past(PC) + 10'h001) else $error("fetch");
	jump_load_a: assert property (x && op == sblu_pkg::OP_JUMP |=>
		FETCH_REQ && PC == $past(SLOT_IN.target)) else $error("jump");
	cond_take_a: assert property (c && tk |=>
		FETCH_REQ && PC == $past(SLOT_IN.target)) else $error("taken");
	cond_fall_a: assert property (c && !tk |=>
		PC == $past(PC) && STACK_OP == 4'h0) else $error("fall");
	loop_push_a: assert property (x && op == sblu_pkg::OP_FOR |=>
		STACK_OP.push_r && STACK_OP.pop_d) else $error("for");
	next_back_a: assert property (lp && !z && op == sblu_pkg::OP_NEXT |=>
		STACK_OP.dec_r && PC == $past(SLOT_IN.target)) else $error("next");
	unext_rep_a: assert property (lp && !z && op == sblu_pkg::OP_UNEXT |=>
		SLOT == 2'h0 && x && STACK_OP.dec_r) else $error("unext");
	loop_exit_a: assert property (lp && z |=>
		STACK_OP.pop_r && (FETCH_REQ || SLOT == $past(SLOT) + 2'h1)) else $error("exit");
endmodule
bind sblu_core sblu_chk #(.ADDR_W(ADDR_W)) chk (.CLK(CLK), .RESET_N(RESET_N),
	.WORD_VALID(WORD_VALID), .SLOT_IN(SLOT_IN), .STACK_IN(STACK_IN), .FETCH_REQ(FETCH_REQ),
	.PC(PC), .SLOT(SLOT), .STACK_OP(STACK_OP));
`default_nettype wire

// [verif/stack_core_branch_loop_unit_tb_top.sv]
// Purpose: Directed bench for the branch and loop unit
// Assumes: Stack tops driven straight on the inputs
// Notes: One slot per test, rest padded
`timescale 1ns/1ps
`default_nettype none
module stack_core_branch_loop_unit_tb_top;
	// ****
	// Bench
	// ****
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	logic word_valid = 1'b0;
	sblu_pkg::sblu_slot_t slot_in = '0;
	sblu_pkg::sblu_stack_t stack_in = '0;
	logic fetch_req;
	logic [9:0] pc;
	logic [1:0] slot;
	sblu_pkg::sblu_stack_op_t stack_op;
	int n_fail = 0;
	int n_tests = 0;
	always #50 clk = !clk;
	sblu_core dut (.CLK(clk), .RESET_N(reset_n), .WORD_VALID(word_valid), .SLOT_IN(slot_in),
		.STACK_IN(stack_in), .FETCH_REQ(fetch_req), .PC(pc), .SLOT(slot), .STACK_OP(stack_op));
	task automatic tally_and_finish;
		$display("tests %0d fails %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic run(input logic [4:0] o, input logic [17:0] v, input logic [2:0] e,
		input logic [3:0] s);
		word_valid = 1'b1;
		@(posedge clk) #1 word_valid = 1'b0;
		slot_in = '{o, 10'h2A};
		stack_in = '{v, v};
		@(posedge clk) #1 n_tests++;
		if (fetch_req !== e[2] || (e[2] ? pc !== 10'h2A : slot !== e[1:0]) || stack_op !== s)
		begin
			n_fail++;
			$display("mismatch at %0t op %h", $time, o);
		end
		slot_in.op = 5'h10;
		while (!fetch_req)
			@(posedge clk) #1;
		$display("op %h done", o);
	endtask
	task automatic jump_test;
		run(sblu_pkg::OP_JUMP, 18'h0, 3'h4, 4'h0);
		run(sblu_pkg::OP_JUMP, 18'h0, 3'h4, 4'h0);
		reset_n = 1'b0;
		#1 n_tests++;
		if (pc !== sblu_pkg::PC_RESET || fetch_req !== 1'b1)
		begin
			n_fail++;
			$display("mismatch at %0t reset exit", $time);
		end
		@(posedge clk) #1 reset_n = 1'b1;
		$display("jump done");
	endtask
	task automatic cond_test;
		run(sblu_pkg::OP_IFZ, 18'h0, 3'h4, 4'h0);
		run(sblu_pkg::OP_IFZ, 18'h1, 3'h1, 4'h0);
		run(sblu_pkg::OP_IFNEG, 18'h1FFFF, 3'h4, 4'h0);
		run(sblu_pkg::OP_IFNEG, 18'h20000, 3'h1, 4'h0);
	endtask
	task automatic loop_test;
		run(sblu_pkg::OP_FOR, 18'h5, 3'h1, 4'h5);
		run(sblu_pkg::OP_NEXT, 18'h1, 3'h4, 4'h2);
		run(sblu_pkg::OP_NEXT, 18'h0, 3'h1, 4'h8);
		run(sblu_pkg::OP_UNEXT, 18'h2, 3'h0, 4'h2);
		run(sblu_pkg::OP_UNEXT, 18'h0, 3'h1, 4'h8);
	endtask
	initial
	begin
		repeat (20) @(posedge clk);
		#1 reset_n = 1'b1;
		jump_test();
		cond_test();
		loop_test();
		tally_and_finish();
	end
	initial
	begin
		#100000;
		n_fail++;
		tally_and_finish();
	end
endmodule
`default_nettype wire
